/* File: logic/icn_params.svh */
`ifndef ICN_PARAMS_SVH
`define ICN_PARAMS_SVH

// Control network dimensions
`define ICN_SLOT_NUM        12
`define ICN_OE_SLOTS        6
`define ICN_CE_NUM          6
`define ICN_DED_IN_NUM      6
`define ICN_DED_CLK_NUM     2
`define ICN_GLOBAL_NUM      4

// Slot positions of the shared functions
`define ICN_SLOT_CE0        6
`define ICN_SLOT_IO_REGISTER_CLOCK_0       6
`define ICN_SLOT_OE6        7
`define ICN_SLOT_IO_REGISTER_CLEAR_0       8
`define ICN_SLOT_OE7        9
`define ICN_SLOT_IO_REGISTER_CLEAR_1       10
`define ICN_SLOT_IO_REGISTER_CLOCK_1       11

// Register byte addresses
`define ICN_CELL_CFG_BASE   12'h000
`define ICN_SLOT_SRC_BASE   12'h100
`define ICN_GLB_CTRL        12'h180
`define ICN_CFG_LOCK        12'h184
`define ICN_BUS_STAT        12'h188
`define ICN_CELL_STAT_BASE  12'h200

// Cell configuration word fields
`define ICN_F_MODE_LSB      0
`define ICN_F_CLK_LSB       2
`define ICN_F_CLR_LSB       4
`define ICN_F_CE_LSB        6
`define ICN_F_OE_LSB        10
`define ICN_F_OUTCOL_BIT    14
`define ICN_F_REG_BIT       15
`define ICN_F_ROW_LSB       16
`define ICN_F_COL_LSB       21
`define ICN_F_COLDRV_BIT    25

// Slot source word fields
`define ICN_S_IDX_LSB       0
`define ICN_S_KIND_LSB      5

// Reset values
`define ICN_CFG_RST         32'h0000_0000
`define ICN_SRC_RST         7'h60

`endif

/* File: logic/icn_pkg.sv */
package icn_pkg;

    // Function of one I/O cell
    typedef enum logic [1:0] {
        ICN_MODE_OFF   = 2'h0,
        ICN_MODE_IN    = 2'h1,
        ICN_MODE_OUT   = 2'h2,
        ICN_MODE_BIDIR = 2'h3
    } icn_mode_t;

    // Register clock choice of one I/O cell
    typedef enum logic [1:0] {
        ICN_CLK_BUS0 = 2'h0,
        ICN_CLK_BUS1 = 2'h1,
        ICN_CLK_PIN0 = 2'h2,
        ICN_CLK_PIN1 = 2'h3
    } icn_clk_sel_t;

    // Source kind of one shared control slot
    typedef enum logic [1:0] {
        ICN_SRC_DED   = 2'h0,
        ICN_SRC_GROUP = 2'h1,
        ICN_SRC_COL   = 2'h2,
        ICN_SRC_OFF   = 2'h3
    } icn_src_kind_t;

endpackage : icn_pkg

/* File: logic/icn_io_cell.sv */
`timescale 1ns/1ps
// One I/O cell: its register, pin drive and input path
module icn_io_cell
    import icn_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      resetn,
    input  wire icn_mode_t mode,
    input  wire logic      use_reg,
    input  wire logic      reg_clk,
    input  wire logic      reg_clr,
    input  wire logic      reg_ce,
    input  wire logic      oe_level,
    input  wire logic      out_data,
    input  wire logic      pin_i,
    input  wire logic      chip_clrn,
    input  wire logic      chip_oe_n,
    output logic           pin_o,
    output logic           pin_oe_n,
    output logic           in_data,
    output logic           q
);

    logic prev_clk_ff;
    logic q_ff;
    logic nxt_q;
    logic pin_o_ff;
    logic pin_oe_n_ff;
    logic in_data_ff;
    logic clk_rise;
    logic drives;

    // Selected clock is a sampled level, so its edge is found here
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) prev_clk_ff <= 1'b0;
        else         prev_clk_ff <= reg_clk;
    end

    assign clk_rise = reg_clk & ~prev_clk_ff;
    assign drives   = (mode == ICN_MODE_OUT) || (mode == ICN_MODE_BIDIR);

    // Cell register; chip reset beats clear, clock and enable
    always_comb begin
        nxt_q = q_ff;
        if (!chip_clrn) begin
            nxt_q = 1'b0;
        end else if (reg_clr) begin
            nxt_q = 1'b0;
        end else if (clk_rise && reg_ce) begin
            // Bidir keeps only the output register in the cell
            nxt_q = (mode == ICN_MODE_IN) ? pin_i : out_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) q_ff <= 1'b0;
        else         q_ff <= nxt_q;
    end

    // Pin drive; chip output enable low releases every pin
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_o_ff    <= 1'b0;
            pin_oe_n_ff <= 1'b1;
        end else begin
            pin_o_ff    <= (use_reg && drives) ? nxt_q : out_data;
            pin_oe_n_ff <= ~(chip_oe_n & drives & oe_level);
        end
    end

    // Input path; bidir input register lives in the fabric, not here
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_data_ff <= 1'b0;
        end else begin
            unique case (mode)
                ICN_MODE_IN:    in_data_ff <= use_reg ? nxt_q : pin_i;
                ICN_MODE_BIDIR: in_data_ff <= pin_i;
                ICN_MODE_OUT:   in_data_ff <= 1'b0;
                ICN_MODE_OFF:   in_data_ff <= 1'b0;
            endcase
        end
    end

    assign pin_o    = pin_o_ff;
    assign pin_oe_n = pin_oe_n_ff;
    assign in_data  = in_data_ff;
    assign q        = q_ff;

endmodule : icn_io_cell

/* File: logic/icn_top.sv */
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "icn_params.svh"

module icn_top
    import icn_pkg::*;
#(
    parameter int N_CELLS  = 8,
    parameter int GROUPS   = 24,
    parameter int ROW_N    = 144,
    parameter int ROW_M    = 18,
    parameter int COL_N    = 24,
    parameter int COL_M    = 16,
    parameter int CELLS_PE = 8
) (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic [11:0]            reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    input  wire logic [5:0]             ded_in,
    input  wire logic [1:0]             ded_clk,
    input  wire logic                   chip_clrn,
    input  wire logic                   chip_oe_n,
    input  wire logic [12*GROUPS-1:0]   group_first_cell,
    input  wire logic [11:0]            col_to_row,
    input  wire logic [N_CELLS-1:0]     fabric_ce,
    input  wire logic [N_CELLS-1:0]     fabric_oe,
    input  wire logic [ROW_N-1:0]       row_ch,
    input  wire logic [COL_N-1:0]       col_ch,
    input  wire logic [N_CELLS-1:0]     pin_i,
    output logic      [N_CELLS-1:0]     pin_o,
    output logic      [N_CELLS-1:0]     pin_oe_n,
    output logic      [2*N_CELLS-1:0]   row_drv,
    output logic      [2*N_CELLS-1:0]   col_drv,
    output logic      [3:0]             low_skew_line,
    output logic      [11:0]            ctrl_bus
);

    localparam int ROW_STEP = ROW_N / ROW_M;

    // Configuration state
    logic [31:0]      cell_cfg_ff [N_CELLS];
    logic [6:0]       slot_src_ff [`ICN_SLOT_NUM];
    logic [3:0]       glb_int_ff;
    logic             cfg_lock_ff;
    logic [31:0]      rdata_ff;

    // Live network state
    logic [11:0]      slot_ff;
    logic [11:0]      nxt_slot;
    logic [3:0]       glb_ff;
    logic [2*N_CELLS-1:0] row_drv_ff;
    logic [2*N_CELLS-1:0] col_drv_ff;

    // Named functions of the shared bus
    logic [7:0]       bus_oe;
    logic [5:0]       bus_ce;
    logic [1:0]       bus_clk;
    logic [1:0]       bus_clr;

    // Per cell wires
    logic [N_CELLS-1:0] c_clk;
    logic [N_CELLS-1:0] c_clr;
    logic [N_CELLS-1:0] c_ce;
    logic [N_CELLS-1:0] c_oe;
    logic [N_CELLS-1:0] c_dat;
    logic [N_CELLS-1:0] c_pin_o;
    logic [N_CELLS-1:0] c_pin_oe_n;
    logic [N_CELLS-1:0] c_in;
    logic [N_CELLS-1:0] c_q;

    // Address decode
    logic [3:0]       region;
    logic [5:0]       widx;
    logic             wr_cfg_ok;

    assign region    = reg_addr[11:8];
    assign widx      = reg_addr[7:2];
    // Static selections: once locked only reset reopens them
    assign wr_cfg_ok = reg_wr && !cfg_lock_ff;

    // Cell configuration words
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < N_CELLS; i++) begin
                cell_cfg_ff[i] <= `ICN_CFG_RST;
            end
        end else if (wr_cfg_ok && region == `ICN_CELL_CFG_BASE / 256) begin
            for (int i = 0; i < N_CELLS; i++) begin
                if (widx == 6'(i)) begin
                    cell_cfg_ff[i] <= reg_wdata;
                end
            end
        end
    end

    // Slot source words; reset leaves every slot undriven
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int s = 0; s < `ICN_SLOT_NUM; s++) begin
                slot_src_ff[s] <= `ICN_SRC_RST;
            end
        end else if (wr_cfg_ok && region == `ICN_SLOT_SRC_BASE / 256 && !reg_addr[7]) begin
            for (int s = 0; s < `ICN_SLOT_NUM; s++) begin
                if (widx == 6'(s)) begin
                    slot_src_ff[s] <= reg_wdata[6:0];
                end
            end
        end
    end

    // Global takeover enables and lock bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            glb_int_ff  <= 4'h0;
            cfg_lock_ff <= 1'b0;
        end else begin
            if (wr_cfg_ok && reg_addr == `ICN_GLB_CTRL) begin
                glb_int_ff <= reg_wdata[3:0];
            end
            // Lock is sticky; writing zero never clears it
            if (reg_wr && reg_addr == `ICN_CFG_LOCK && reg_wdata[0]) begin
                cfg_lock_ff <= 1'b1;
            end
        end
    end

    // Source of each slot: dedicated pin, group head cell or column route
    always_comb begin
        nxt_slot = 12'h000;
        for (int s = 0; s < `ICN_SLOT_NUM; s++) begin
            unique case (icn_src_kind_t'(slot_src_ff[s][`ICN_S_KIND_LSB +: 2]))
                ICN_SRC_DED: begin
                    for (int d = 0; d < `ICN_DED_IN_NUM; d++) begin
                        if (slot_src_ff[s][4:0] == 5'(d)) nxt_slot[s] = ded_in[d];
                    end
                end
                ICN_SRC_GROUP: begin
                    for (int g = 0; g < GROUPS; g++) begin
                        if (slot_src_ff[s][4:0] == 5'(g)) begin
                            nxt_slot[s] = group_first_cell[s*GROUPS+g];
                        end
                    end
                end
                ICN_SRC_COL: nxt_slot[s] = col_to_row[s];
                ICN_SRC_OFF: nxt_slot[s] = 1'b0;
            endcase
        end
    end

    // Twelve registered slots drive every cell evenly
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) slot_ff <= 12'h000;
        else         slot_ff <= nxt_slot;
    end

    // Fixed function sharing of the slots
    assign bus_oe[5:0] = slot_ff[5:0];
    assign bus_oe[6]   = slot_ff[`ICN_SLOT_OE6];
    assign bus_oe[7]   = slot_ff[`ICN_SLOT_OE7];
    assign bus_ce      = slot_ff[11:6];
    assign bus_clk     = {slot_ff[`ICN_SLOT_IO_REGISTER_CLOCK_1], slot_ff[`ICN_SLOT_IO_REGISTER_CLOCK_0]};
    assign bus_clr     = {slot_ff[`ICN_SLOT_IO_REGISTER_CLEAR_1], slot_ff[`ICN_SLOT_IO_REGISTER_CLEAR_0]};

    // Low-skew lines: internal slot takes over, else dedicated pin.
    // The pin whose line is taken over is ignored and must be tied.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            glb_ff <= 4'h0;
        end else begin
            glb_ff[0] <= glb_int_ff[0] ? bus_ce[0] : ded_in[0];
            glb_ff[1] <= glb_int_ff[1] ? bus_ce[1] : ded_in[1];
            glb_ff[2] <= glb_int_ff[2] ? bus_ce[3] : ded_in[2];
            glb_ff[3] <= glb_int_ff[3] ? bus_ce[5] : ded_in[3];
        end
    end

    // Per cell selection and the cell itself
    for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
        logic [31:0] cfg;
        logic [4:0]  row_sel;
        logic [3:0]  col_sel;
        logic [3:0]  ce_sel;
        logic [3:0]  oe_sel;

        assign cfg     = cell_cfg_ff[i];
        assign row_sel = cfg[`ICN_F_ROW_LSB +: 5];
        assign col_sel = cfg[`ICN_F_COL_LSB +: 4];
        assign ce_sel  = cfg[`ICN_F_CE_LSB +: 4];
        assign oe_sel  = cfg[`ICN_F_OE_LSB +: 4];

        // Register clock from bus clocks or dedicated clock pins
        always_comb begin
            unique case (icn_clk_sel_t'(cfg[`ICN_F_CLK_LSB +: 2]))
                ICN_CLK_BUS0: c_clk[i] = bus_clk[0];
                ICN_CLK_BUS1: c_clk[i] = bus_clk[1];
                ICN_CLK_PIN0: c_clk[i] = ded_clk[0];
                ICN_CLK_PIN1: c_clk[i] = ded_clk[1];
            endcase
        end

        // Clear: none, bus clear 0 or bus clear 1
        always_comb begin
            unique case (cfg[`ICN_F_CLR_LSB +: 2])
                2'h1:    c_clr[i] = bus_clr[0];
                2'h2:    c_clr[i] = bus_clr[1];
                default: c_clr[i] = 1'b0;
            endcase
        end

        // Clock enable: always, one of six bus enables, or fabric cell
        always_comb begin
            c_ce[i] = 1'b0;
            if (ce_sel == 4'h0) begin
                c_ce[i] = 1'b1;
            end else if (ce_sel == 4'h7) begin
                c_ce[i] = fabric_ce[i];
            end else begin
                for (int k = 0; k < `ICN_CE_NUM; k++) begin
                    if (ce_sel == 4'(k + 1)) c_ce[i] = bus_ce[k];
                end
            end
        end

        // Output enable: always, one of eight bus enables, or fabric cell
        always_comb begin
            c_oe[i] = 1'b0;
            if (oe_sel == 4'h0) begin
                c_oe[i] = 1'b1;
            end else if (oe_sel == 4'h9) begin
                c_oe[i] = fabric_oe[i];
            end else begin
                for (int k = 0; k < 8; k++) begin
                    if (oe_sel == 4'(k + 1)) c_oe[i] = bus_oe[k];
                end
            end
        end

        // Output data: row mux over a strided subset, or column mux
        // whose window is shifted per cell. Out of range picks read 0.
        always_comb begin
            c_dat[i] = 1'b0;
            if (cfg[`ICN_F_OUTCOL_BIT]) begin
                for (int k = 0; k < COL_M; k++) begin
                    if (col_sel == 4'(k)) c_dat[i] = col_ch[(k + 2*i) % COL_N];
                end
            end else begin
                for (int k = 0; k < ROW_M; k++) begin
                    if (row_sel == 5'(k)) begin
                        c_dat[i] = row_ch[k*ROW_STEP + (i % CELLS_PE)];
                    end
                end
            end
        end

        icn_io_cell u_cell (
            .clk       (clk),
            .resetn    (resetn),
            .mode      (icn_mode_t'(cfg[`ICN_F_MODE_LSB +: 2])),
            .use_reg   (cfg[`ICN_F_REG_BIT]),
            .reg_clk   (c_clk[i]),
            .reg_clr   (c_clr[i]),
            .reg_ce    (c_ce[i]),
            .oe_level  (c_oe[i]),
            .out_data  (c_dat[i]),
            .pin_i     (pin_i[i]),
            .chip_clrn (chip_clrn),
            .chip_oe_n (chip_oe_n),
            .pin_o     (c_pin_o[i]),
            .pin_oe_n  (c_pin_oe_n[i]),
            .in_data   (c_in[i]),
            .q         (c_q[i])
        );

        // Input cells fan out to two row and up to two column channels
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                row_drv_ff[2*i +: 2] <= 2'h0;
                col_drv_ff[2*i +: 2] <= 2'h0;
            end else begin
                row_drv_ff[2*i +: 2] <= {2{c_in[i]}};
                col_drv_ff[2*i +: 2] <= cfg[`ICN_F_COLDRV_BIT] ? {2{c_in[i]}} : 2'h0;
            end
        end
    end

    // Read port; data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= 32'h0000_0000;
            if (reg_rd) begin
                if (region == `ICN_CELL_CFG_BASE / 256) begin
                    for (int i = 0; i < N_CELLS; i++) begin
                        if (widx == 6'(i)) rdata_ff <= cell_cfg_ff[i];
                    end
                end else if (region == `ICN_SLOT_SRC_BASE / 256 && !reg_addr[7]) begin
                    for (int s = 0; s < `ICN_SLOT_NUM; s++) begin
                        if (widx == 6'(s)) rdata_ff <= {25'h0, slot_src_ff[s]};
                    end
                end else if (reg_addr == `ICN_GLB_CTRL) begin
                    rdata_ff <= {28'h0, glb_int_ff};
                end else if (reg_addr == `ICN_CFG_LOCK) begin
                    rdata_ff <= {31'h0, cfg_lock_ff};
                end else if (reg_addr == `ICN_BUS_STAT) begin
                    rdata_ff <= {12'h0, glb_ff, 4'h0, slot_ff};
                end else if (region == `ICN_CELL_STAT_BASE / 256) begin
                    for (int i = 0; i < N_CELLS; i++) begin
                        if (widx == 6'(i)) begin
                            rdata_ff <= {28'h0, c_pin_oe_n[i], c_pin_o[i], c_in[i], c_q[i]};
                        end
                    end
                end
            end
        end
    end

    // Every output is a flop, here or inside a cell
    assign reg_rdata     = rdata_ff;
    assign pin_o         = c_pin_o;
    assign pin_oe_n      = c_pin_oe_n;
    assign row_drv       = row_drv_ff;
    assign col_drv       = col_drv_ff;
    assign low_skew_line = glb_ff;
    assign ctrl_bus      = slot_ff;

endmodule : icn_top

/* File: tb/icn_properties.sv */
`timescale 1ns/1ps
// Watches the control network from the top ports only
module icn_checker #(
    parameter int N_CELLS = 8,
    parameter int GROUPS  = 24
) (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic [11:0]          reg_addr,
    input wire logic [31:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    input wire logic [5:0]           ded_in,
    input wire logic                 chip_oe_n,
    input wire logic [12*GROUPS-1:0] group_first_cell,
    input wire logic [11:0]          col_to_row,
    input wire logic [N_CELLS-1:0]   pin_oe_n,
    input wire logic [2*N_CELLS-1:0] row_drv,
    input wire logic [2*N_CELLS-1:0] col_drv,
    input wire logic [3:0]           low_skew_line,
    input wire logic [11:0]          ctrl_bus
);
    localparam logic [2*N_CELLS-1:0] even_bits = {N_CELLS{2'h1}};
    logic [6:0]  src_ff [12];
    logic [3:0]  tk_ff;
    logic        lk_ff;
    logic        up_ff;
    logic [11:0] exp_bus;
    logic [3:0]  exp_glb;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Shadow copies; the lock freezes them just as it freezes the block
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            src_ff <= '{default: 7'h60};
            tk_ff  <= 4'h0;
            lk_ff  <= 1'b0;
            up_ff  <= 1'b0;
        end else begin
            up_ff <= 1'b1;
            if (reg_wr && reg_addr == 12'h184 && reg_wdata[0]) lk_ff <= 1'b1;
            if (reg_wr && !lk_ff && reg_addr == 12'h180) tk_ff <= reg_wdata[3:0];
            if (reg_wr && !lk_ff && reg_addr[11:6] == 6'h04 && reg_addr[5:2] < 4'hC)
                src_ff[reg_addr[5:2]] <= reg_wdata[6:0];
        end
    end

    // Slot value expected from the chosen source
    always_comb begin
        for (int s = 0; s < 12; s++) begin
            case (src_ff[s][6:5])
                // An index past the last pin or group selects nothing, so the slot reads low
                2'h0: exp_bus[s] = (src_ff[s][4:0] < 5'h06) ? ded_in[src_ff[s][2:0]] : 1'b0;
                2'h1: exp_bus[s] = (src_ff[s][4:0] < 5'(GROUPS)) ?
                                   group_first_cell[s*GROUPS+int'(src_ff[s][4:0])] : 1'b0;
                2'h2: exp_bus[s] = col_to_row[s];
                default: exp_bus[s] = 1'b0;
            endcase
        end
    end

    // Lines taken over follow CE slots 0, 1, 3 and 5
    assign exp_glb = (tk_ff & {ctrl_bus[11], ctrl_bus[9], ctrl_bus[7], ctrl_bus[6]}) | (~tk_ff & ded_in[3:0]);

    property p_slot_source;
        up_ff |-> ctrl_bus == $past(exp_bus);
    endproperty
    a_slot_source: assert property (p_slot_source) else $error("slot mismatch");
    property p_global_line;
        up_ff |-> low_skew_line == $past(exp_glb);
    endproperty
    a_global_line: assert property (p_global_line) else $error("global mismatch");
    property p_bus_status;
        reg_rd && reg_addr == 12'h188 |=> reg_rdata == {12'h0, $past(low_skew_line), 4'h0, $past(ctrl_bus)};
    endproperty
    a_bus_status: assert property (p_bus_status) else $error("status mismatch");
    property p_chip_oe;
        !chip_oe_n |=> pin_oe_n == '1;
    endproperty
    a_chip_oe: assert property (p_chip_oe) else $error("pin still driven");
    property p_oe_hold;
        !chip_oe_n [*2] |-> pin_oe_n == '1;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pin driven while held");
    property p_row_pair;
        ((row_drv ^ (row_drv >> 1)) & even_bits) == '0;
    endproperty
    a_row_pair: assert property (p_row_pair) else $error("row pair split");
    property p_col_pair;
        ((col_drv ^ (col_drv >> 1)) & even_bits) == '0;
    endproperty
    a_col_pair: assert property (p_col_pair) else $error("column pair split");
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule : icn_checker

bind icn_top icn_checker #(.N_CELLS(N_CELLS), .GROUPS(GROUPS)) chk_u (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ded_in(ded_in), .chip_oe_n(chip_oe_n),
    .group_first_cell(group_first_cell), .col_to_row(col_to_row), .pin_oe_n(pin_oe_n),
    .row_drv(row_drv), .col_drv(col_drv), .low_skew_line(low_skew_line), .ctrl_bus(ctrl_bus));

/* File: tb/icn_pad_model.sv */
`timescale 1ns/1ps
// Package pins: a released pin shows the board level, else its pull-up
module icn_pad_model #(
    parameter int N = 8
) (
    input  wire logic [N-1:0] pin_o,
    input  wire logic [N-1:0] pin_oe_n,
    input  wire logic [N-1:0] ext_en,
    input  wire logic [N-1:0] ext_val,
    output logic      [N-1:0] pin_i
);
    // Cell drive wins; never leaves an unknown on a floating pin
    assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en);
endmodule : icn_pad_model

/* File: tb/tb_io_cell_control_network.sv */
`timescale 1ns/1ps
// Self-checking bench for the I/O control network
module tb_io_cell_control_network;
    typedef struct {logic [11:0] addr; logic [31:0] wdata; logic [31:0] rexp;} icn_row_t;
    logic         clk, resetn, reg_wr, reg_rd, chip_clrn, chip_oe_n;
    logic [11:0]  reg_addr, col_to_row, ctrl_bus;
    logic [31:0]  reg_wdata, reg_rdata, rd_val;
    logic [5:0]   ded_in;
    logic [1:0]   ded_clk;
    logic [287:0] group_first_cell;
    logic [7:0]   fabric_ce, fabric_oe, pin_i, pin_o, pin_oe_n, ext_en, ext_val;
    logic [143:0] row_ch;
    logic [23:0]  col_ch;
    logic [15:0]  row_drv, col_drv;
    logic [3:0]   low_skew_line;
    int           fails, total_checks, cycles;
    // Configuration rows; the last three land on refused places
    icn_row_t rows [9] = '{'{12'h000, 32'h0001_0002, 32'h0001_0002}, '{12'h004, 32'h0000_0402, 32'h0000_0402},
        '{12'h008, 32'h0000_81CA, 32'h0000_81CA}, '{12'h00C, 32'h0200_0001, 32'h0200_0001},
        '{12'h100, 32'h0000_0000, 32'h0000_0000}, '{12'h118, 32'h0000_0005, 32'h0000_0005},
        '{12'h130, 32'h0000_0001, 32'h0000_0000}, '{12'h020, 32'h0000_0003, 32'h0000_0000},
        '{12'h300, 32'hFFFF_FFFF, 32'h0000_0000}};

    icn_top dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ded_in(ded_in), .ded_clk(ded_clk), .chip_clrn(chip_clrn),
        .chip_oe_n(chip_oe_n), .group_first_cell(group_first_cell), .col_to_row(col_to_row),
        .fabric_ce(fabric_ce), .fabric_oe(fabric_oe), .row_ch(row_ch), .col_ch(col_ch), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_n(pin_oe_n), .row_drv(row_drv), .col_drv(col_drv),
        .low_skew_line(low_skew_line), .ctrl_bus(ctrl_bus));
    icn_pad_model pad_u (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));

    always #2 clk = ~clk;

    // Hang guard, well beyond the roughly 115 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        // One idle edge, so a following write never re-raises the strobe in the same step
        @(posedge clk);
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        rd_val = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic end_of_test();
        $display("fails=%0d total_checks=%0d", fails, total_checks);
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        {clk, resetn, reg_wr, reg_rd, reg_addr, reg_wdata, ded_in, ded_clk} = '0;
        {chip_clrn, chip_oe_n, fabric_ce} = '1;
        {group_first_cell, col_to_row, fabric_oe, row_ch, col_ch, ext_en, ext_val} = '0;
        {fails, total_checks, cycles} = '0;
        tick(5);
        chk(32'(pin_oe_n), 32'hFF);
        resetn <= 1'b1;
        tick(1);
        rd(12'h104);
        chk(rd_val, 32'h60);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr);
            chk(rd_val, rows[i].rexp);
        end
        // Slot 0 enables cell 1, slot 6 carries a dedicated input
        ded_in <= 6'h21;
        row_ch[8] <= 1'b1;
        row_ch[1] <= 1'b1;
        tick(4);
        chk(32'(ctrl_bus), 32'h041);
        chk(32'(pin_oe_n[1:0]), 32'h0);
        chk(32'(pin_o[1:0]), 32'h3);
        rd(12'h188);
        chk(rd_val, 32'h0001_0041);
        ded_in <= 6'h20; // Held low from here on, its line is taken over later
        tick(4);
        chk(32'(pin_oe_n[1]), 32'h1);
        chip_oe_n <= 1'b0;
        tick(3);
        chk(32'(pin_oe_n), 32'hFF);
        chip_oe_n <= 1'b1;
        // Cell 2 register: dedicated clock pin, fabric enable, chip clear
        row_ch[2] <= 1'b1;
        fabric_ce[2] <= 1'b0;
        ded_clk[0] <= 1'b1;
        tick(3);
        ded_clk[0] <= 1'b0;
        tick(3);
        chk(32'(pin_o[2]), 32'h0);
        fabric_ce[2] <= 1'b1;
        ded_clk[0] <= 1'b1;
        tick(3);
        chk(32'(pin_o[2]), 32'h1);
        ded_clk[0] <= 1'b0;
        tick(2);
        chip_clrn <= 1'b0;
        ded_clk[0] <= 1'b1;
        tick(3);
        chk(32'(pin_o[2]), 32'h0);
        chip_clrn <= 1'b1;
        // Cell 3 as input, both levels
        ext_en[3] <= 1'b1;
        for (int v = 1; v >= 0; v--) begin
            ext_val[3] <= v[0];
            tick(4);
            chk(32'(row_drv[7:6]), 32'(3 * v));
            chk(32'(col_drv[7:6]), 32'(3 * v));
        end
        // Group head and column route feed slots; cell 4 uses its shifted column window, cell 5 is bidir
        wr(12'h11C, 32'h0000_0023);
        wr(12'h120, 32'h0000_0040);
        wr(12'h010, 32'h0020_4002);
        wr(12'h014, 32'h0000_2403);
        group_first_cell[171] <= 1'b1;
        col_to_row[8] <= 1'b1;
        col_ch[9] <= 1'b1;
        fabric_oe[5] <= 1'b1;
        tick(3);
        chk(32'(ctrl_bus), 32'h1C0);
        chk(32'(pin_o[4]), 32'h1);
        chk(32'(pin_oe_n[5]), 32'h0);
        // Released bidir pin floats to its pull-up and still reaches the row channels
        fabric_oe[5] <= 1'b0;
        tick(4);
        chk(32'(row_drv[11:10]), 32'h3);
        wr(12'h180, 32'h1);
        tick(3);
        chk(32'(low_skew_line), 32'h1);
        // Once locked, writes are dropped until reset
        wr(12'h184, 32'h1);
        wr(12'h000, 32'h0);
        wr(12'h180, 32'h0);
        rd(12'h000);
        chk(rd_val, 32'h0001_0002);
        chk(32'(low_skew_line), 32'h1);
        resetn <= 1'b0;
        tick(2);
        resetn <= 1'b1;
        tick(1);
        rd(12'h000);
        chk(rd_val, 32'h0);
        end_of_test();
    end
endmodule : tb_io_cell_control_network
